//--- shared/spms_pkg.sv
/*
 Shared constants for the serial port: register offsets, field positions,
 reset values, timing figures and the master state encoding.
 Assumes an 8-bit register port and a 50 MHz core clock.
*/
package spms_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          BYTE_W        = 8;

    localparam logic [7:0]  TX_OFS        = 8'h9A;
    localparam logic [7:0]  RX_OFS        = 8'h9B;
    localparam logic [7:0]  CFG1_OFS      = 8'hE8;
    localparam logic [7:0]  CFG2_OFS      = 8'hE9;
    localparam logic [7:0]  STAT_OFS      = 8'hEA;

    localparam logic [7:0]  CFG1_RST      = 8'h00;
    localparam logic [7:0]  CFG2_RST      = 8'h00;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;

    // serial_config_one fields
    localparam int          C1_EN         = 7;
    localparam int          C1_TRANSMIT_INTERRUPT_MODE     = 6;
    localparam int          C1_MASTER     = 5;
    localparam int          C1_AUTO_SS    = 4;
    localparam int          C1_SS_IN      = 3;
    localparam int          C1_OVW        = 2;
    localparam int          C1_RATE_LO    = 0;
    localparam int          RATE_W        = 2;

    // serial_config_two fields
    localparam int          C2_CONT       = 7;
    localparam int          C2_CPOL       = 3;
    localparam int          C2_CPHA       = 2;

    // serial_flag_register fields
    localparam int          ST_OVF        = 5;
    localparam int          ST_RXNEW      = 4;
    localparam int          ST_RXFULL     = 3;
    localparam int          ST_TXEMPTY    = 1;
    localparam int          ST_TXFULL     = 0;

    localparam logic [2:0]  BIT_LAST      = 3'h7;
    localparam logic [2:0]  BIT_FIRST     = 3'h0;
    localparam logic [3:0]  EDGE_LAST     = 4'hF;
    localparam logic [3:0]  EDGE_FIRST    = 4'h0;

    localparam int          REF_PERIOD_NS = 20;
    localparam int          SCLK_HALF_NS  = 100;
    localparam int          HALF_CYC      = (SCLK_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LEAD  = 3'b001,
        ST_XFER  = 3'b010,
        ST_GAP   = 3'b011,
        ST_TRAIL = 3'b100
    } spms_state_type;

endpackage : spms_pkg

//--- core/spms_sync.sv
/*
 Two-flip-flop synchroniser for pin inputs.
 Assumes inputs are asynchronous levels; only the second stage is read.
*/
`timescale 1ns/10ps
module spms_sync #(
    parameter int W = 1
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    initial
    begin
        if (W < 1) $error("spms_sync: W must be at least 1");
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_r <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule : spms_sync

//--- core/spms_clkdiv.sv
/*
 Half-period tick generator for the master serial clock.
 Assumes i_run is held high for the whole frame; the count restarts when low.
*/
`timescale 1ns/10ps
module spms_clkdiv #(
    parameter int HALF_CYC = spms_pkg::HALF_CYC
) (
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_run,
    input  wire logic [spms_pkg::RATE_W-1:0] i_rate,
    output logic                             o_tick
);
    localparam int CNT_W = $clog2(HALF_CYC * 8) + 1;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] limit;

    initial
    begin
        if (HALF_CYC < 1) $error("spms_clkdiv: HALF_CYC must be at least 1");
    end

    // Each rate step doubles the half period
    assign limit  = CNT_W'(HALF_CYC) << i_rate;
    assign o_tick = i_run && (cnt_r == limit - CNT_W'(1));

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_r <= '0;
        else if (!i_run || o_tick)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + CNT_W'(1);
    end

endmodule : spms_clkdiv

//--- core/spms_port.sv
/*
 Serial peripheral port, master or slave, with double-buffered transmit and
 receive registers, automatic select, continuous streaming and overflow flags.
 Assumes a synchronous register port (read data one cycle after the strobe)
 and pin inputs that are asynchronous to i_ref_clk.
*/
// Chosen here: strobed register access.
`timescale 1ns/10ps
module spms_port #(
    parameter int HALF_CYC = spms_pkg::HALF_CYC
) (
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_rst_n,
    input  wire logic [spms_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [spms_pkg::BYTE_W-1:0] i_wr_data,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [spms_pkg::BYTE_W-1:0] o_rd_data,
    input  wire logic                        i_sclk,
    output logic                             o_sclk,
    output logic                             o_sclk_oe,
    input  wire logic                        i_mosi,
    output logic                             o_mosi,
    output logic                             o_mosi_oe,
    input  wire logic                        i_miso,
    output logic                             o_miso,
    output logic                             o_miso_oe,
    input  wire logic                        i_ss_n,
    output logic                             o_ss_n,
    output logic                             o_ss_n_oe
);
    localparam int BW = spms_pkg::BYTE_W;

    initial
    begin
        if (HALF_CYC < 1) $error("spms_port: HALF_CYC must be at least 1");
    end

    function automatic logic [BW-1:0] shift_in(input logic [BW-1:0] v, input logic b);
        shift_in = {v[BW-2:0], b};
    endfunction : shift_in

    logic [BW-1:0]              cfg1_r;
    logic [BW-1:0]              cfg2_r;
    logic [BW-1:0]              txbuf_r;
    logic [BW-1:0]              rxbuf_r;
    logic [BW-1:0]              sh_tx_r;
    logic [BW-1:0]              sh_rx_r;
    logic [BW-1:0]              rd_data_r;
    logic                       tx_full_r;
    logic                       tx_empty_r;
    logic                       rx_new_r;
    logic                       rx_full_r;
    logic                       ovf_r;
    logic [2:0]                 bitcnt_r;
    logic [3:0]                 edge_r;
    logic                       sclk_r;
    logic                       ss_out_n_r;
    logic                       sclk_q_r;
    logic                       ss_q_r;
    spms_pkg::spms_state_type   state_r;
    spms_pkg::spms_state_type   state_nxt;

    logic [3:0]                 pins_s;
    logic                       sclk_s;
    logic                       mosi_s;
    logic                       miso_s;
    logic                       ss_s;
    logic                       tick;
    logic                       en;
    logic                       master;
    logic                       slave;
    logic                       cpol;
    logic                       cpha;
    logic                       cont;
    logic                       m_lead;
    logic                       m_trail;
    logic                       s_sel;
    logic                       s_edge;
    logic                       lead;
    logic                       trail;
    logic                       sample;
    logic                       launch;
    logic                       rx_in;
    logic                       byte_done;
    logic                       go_on;
    logic                       load_m;
    logic                       load_s;
    logic                       load;
    logic                       wr_tx;
    logic                       wr_st;
    logic                       rd_rx;
    logic                       rx_busy;

    spms_sync #(
        .W        (4)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n  (i_rst_n),
        .i_async  ({i_sclk, i_mosi, i_miso, i_ss_n}),
        .o_sync   (pins_s)
    );

    assign {sclk_s, mosi_s, miso_s, ss_s} = pins_s;

    spms_clkdiv #(
        .HALF_CYC (HALF_CYC)
    ) u_div (
        .i_ref_clk(i_ref_clk),
        .i_rst_n  (i_rst_n),
        .i_run    (master && (state_r != spms_pkg::ST_IDLE)),
        .i_rate   (cfg1_r[spms_pkg::C1_RATE_LO +: spms_pkg::RATE_W]),
        .o_tick   (tick)
    );

    assign en     = cfg1_r[spms_pkg::C1_EN];
    assign master = en && cfg1_r[spms_pkg::C1_MASTER];
    assign slave  = en && !cfg1_r[spms_pkg::C1_MASTER];
    assign cpol   = cfg2_r[spms_pkg::C2_CPOL];
    assign cpha   = cfg2_r[spms_pkg::C2_CPHA];
    assign cont   = cfg2_r[spms_pkg::C2_CONT];

    assign wr_tx  = i_wr && (i_addr == spms_pkg::TX_OFS);
    assign wr_st  = i_wr && (i_addr == spms_pkg::STAT_OFS);
    assign rd_rx  = i_rd && (i_addr == spms_pkg::RX_OFS);

    // Pin directions follow the role
    assign o_sclk_oe = master;
    assign o_mosi_oe = master;
    assign o_miso_oe = slave && !ss_s;
    assign o_ss_n_oe = master && cfg1_r[spms_pkg::C1_AUTO_SS]
                       && !cfg1_r[spms_pkg::C1_SS_IN];
    assign o_sclk    = sclk_r;
    assign o_mosi    = sh_tx_r[BW-1];
    assign o_miso    = sh_tx_r[BW-1];
    assign o_ss_n    = ss_out_n_r;
    assign o_rd_data = rd_data_r;

    // Edge decode: leading leaves the idle level, trailing returns to it
    assign m_lead  = master && (state_r == spms_pkg::ST_XFER) && tick && (sclk_r == cpol);
    assign m_trail = master && (state_r == spms_pkg::ST_XFER) && tick && (sclk_r != cpol);
    assign s_sel   = slave && !ss_s && !ss_q_r;
    assign s_edge  = s_sel && (sclk_s != sclk_q_r);
    assign lead    = m_lead || (s_edge && (sclk_s != cpol));
    assign trail   = m_trail || (s_edge && (sclk_s == cpol));
    assign sample  = cpha ? trail : lead;
    assign launch  = cpha ? lead : trail;
    assign rx_in   = master ? miso_s : mosi_s;
    assign byte_done = sample && (bitcnt_r == spms_pkg::BIT_LAST);
    assign rx_busy = rx_full_r && !rd_rx;

    // Next byte only if the buffer was refilled in time; with transmit-interrupt
    // mode off an unread receive byte also ends the frame
    assign go_on = tx_full_r && (cfg1_r[spms_pkg::C1_TRANSMIT_INTERRUPT_MODE] || !rx_new_r);

    always_comb
    begin
        state_nxt = state_r;
        load_m    = 1'b0;
        if (!master)
            state_nxt = spms_pkg::ST_IDLE;
        else
        begin
            case (state_r)
                spms_pkg::ST_IDLE:
                    if (tx_full_r)
                        state_nxt = spms_pkg::ST_LEAD;
                spms_pkg::ST_LEAD:
                    if (tick)
                    begin
                        state_nxt = spms_pkg::ST_XFER;
                        load_m    = 1'b1;
                    end
                spms_pkg::ST_XFER:
                    if (tick && (edge_r == spms_pkg::EDGE_LAST))
                    begin
                        if (go_on && cont)
                            load_m    = 1'b1;
                        else if (go_on)
                            state_nxt = spms_pkg::ST_GAP;
                        else
                            state_nxt = spms_pkg::ST_TRAIL;
                    end
                spms_pkg::ST_GAP:
                    if (tick)
                    begin
                        state_nxt = spms_pkg::ST_XFER;
                        load_m    = 1'b1;
                    end
                spms_pkg::ST_TRAIL:
                    if (tick)
                        state_nxt = spms_pkg::ST_IDLE;
                default:
                    state_nxt = spms_pkg::ST_IDLE;
            endcase
        end
    end

    // Slave reloads at select fall and after every eighth sample
    assign load_s = slave && ((!ss_s && ss_q_r) || (s_sel && byte_done));
    assign load   = load_m || load_s;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_r <= spms_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sclk_r     <= 1'b0;
            edge_r     <= spms_pkg::EDGE_FIRST;
            ss_out_n_r <= 1'b1;
        end
        else
        begin
            if (state_r == spms_pkg::ST_XFER && tick)
                sclk_r <= ~sclk_r;
            else if (state_r != spms_pkg::ST_XFER)
                sclk_r <= cpol;
            if (load_m)
                edge_r <= spms_pkg::EDGE_FIRST;
            else if (state_r == spms_pkg::ST_XFER && tick)
                edge_r <= edge_r + 4'h1;
            ss_out_n_r <= (state_nxt == spms_pkg::ST_IDLE);
        end
    end

    // Shifters: no shift on the launch edge that opens a byte, since the load
    // already presented its first bit
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sh_tx_r  <= spms_pkg::BYTE_ZERO;
            sh_rx_r  <= spms_pkg::BYTE_ZERO;
            bitcnt_r <= spms_pkg::BIT_FIRST;
            sclk_q_r <= 1'b0;
            ss_q_r   <= 1'b1;
        end
        else
        begin
            sclk_q_r <= sclk_s;
            ss_q_r   <= ss_s;
            if (load)
                sh_tx_r <= txbuf_r;
            else if (launch && (bitcnt_r != spms_pkg::BIT_FIRST))
                sh_tx_r <= shift_in(sh_tx_r, 1'b0);
            if (sample)
                sh_rx_r <= shift_in(sh_rx_r, rx_in);
            if ((load_m && state_r != spms_pkg::ST_XFER) || (slave && ss_s))
                bitcnt_r <= spms_pkg::BIT_FIRST;
            else if (sample)
                bitcnt_r <= bitcnt_r + 3'h1;
        end
    end

    // Transmit buffer and its flags; a new write beats a same-cycle clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            txbuf_r    <= spms_pkg::BYTE_ZERO;
            tx_full_r  <= 1'b0;
            tx_empty_r <= 1'b0;
        end
        else
        begin
            if (wr_tx)
                txbuf_r <= i_wr_data;
            if (wr_tx)
                tx_full_r <= 1'b1;
            else if (load || (wr_st && !i_wr_data[spms_pkg::ST_TXFULL]))
                tx_full_r <= 1'b0;
            if (load && tx_full_r)
                tx_empty_r <= 1'b1;
            else if (wr_tx || (wr_st && !i_wr_data[spms_pkg::ST_TXEMPTY]))
                tx_empty_r <= 1'b0;
        end
    end

    // Receive buffer and its flags; a delivery beats a same-cycle read
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rxbuf_r   <= spms_pkg::BYTE_ZERO;
            rx_new_r  <= 1'b0;
            rx_full_r <= 1'b0;
            ovf_r     <= 1'b0;
        end
        else
        begin
            if (byte_done && (!rx_busy || cfg1_r[spms_pkg::C1_OVW]))
                rxbuf_r <= shift_in(sh_rx_r, rx_in);
            if (byte_done)
            begin
                rx_new_r  <= 1'b1;
                rx_full_r <= 1'b1;
            end
            else if (rd_rx)
            begin
                rx_new_r  <= 1'b0;
                rx_full_r <= 1'b0;
            end
            if (byte_done && rx_busy)
                ovf_r <= 1'b1;
            else if (wr_st && !i_wr_data[spms_pkg::ST_OVF])
                ovf_r <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cfg1_r <= spms_pkg::CFG1_RST;
            cfg2_r <= spms_pkg::CFG2_RST;
        end
        else if (i_wr)
        begin
            if (i_addr == spms_pkg::CFG1_OFS)
                cfg1_r <= i_wr_data;
            if (i_addr == spms_pkg::CFG2_OFS)
                cfg2_r <= i_wr_data;
        end
    end

    // Read data stand only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rd_data_r <= spms_pkg::BYTE_ZERO;
        else if (!i_rd)
            rd_data_r <= spms_pkg::BYTE_ZERO;
        else
        begin
            case (i_addr)
                spms_pkg::RX_OFS:   rd_data_r <= rxbuf_r;
                spms_pkg::CFG1_OFS: rd_data_r <= cfg1_r;
                spms_pkg::CFG2_OFS: rd_data_r <= cfg2_r;
                spms_pkg::STAT_OFS:
                begin
                    rd_data_r                       <= spms_pkg::BYTE_ZERO;
                    rd_data_r[spms_pkg::ST_OVF]     <= ovf_r;
                    rd_data_r[spms_pkg::ST_RXNEW]   <= rx_new_r;
                    rd_data_r[spms_pkg::ST_RXFULL]  <= rx_full_r;
                    rd_data_r[spms_pkg::ST_TXEMPTY] <= tx_empty_r;
                    rd_data_r[spms_pkg::ST_TXFULL]  <= tx_full_r;
                end
                default:            rd_data_r <= spms_pkg::BYTE_ZERO;
            endcase
        end
    end

endmodule : spms_port

//--- tb/spms_props.sv
/*
 Pin checker for the serial port, bound to spms_port.
 Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/10ps
module spms_props #(
    parameter int HALF_CYC = 5
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic o_sclk,
    input wire logic o_sclk_oe,
    input wire logic o_mosi,
    input wire logic o_mosi_oe,
    input wire logic o_miso_oe,
    input wire logic o_ss_n,
    input wire logic o_ss_n_oe
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Bench runs HALF_CYC=4, so every half period spans four cycles
    dir_swap_a: assert property (o_miso_oe |-> !o_mosi_oe) else $error("data pins both out");
    sclk_dir_a: assert property (o_sclk_oe == o_mosi_oe) else $error("clock pin direction");
    sel_input_a: assert property (o_miso_oe |-> !o_ss_n_oe) else $error("select driven as slave");
    sel_cfg_a: assert property (o_ss_n_oe |-> o_sclk_oe) else $error("select driven off master");
    reset_idle_a: assert property (!$past(i_rst_n) |-> o_ss_n && !o_sclk_oe && !o_miso_oe)
        else $error("not idle after reset");
    lead_gap_a: assert property ($fell(o_ss_n) |-> $stable(o_sclk)[*3]) else $error("no lead time");
    sclk_half_a: assert property (!o_ss_n && $changed(o_sclk) |=> $stable(o_sclk)[*3])
        else $error("half period short");
    mosi_hold_a: assert property (!o_ss_n && o_mosi_oe && $changed(o_mosi) |=> $stable(o_mosi)[*3])
        else $error("data not held");
endmodule : spms_props

bind spms_port spms_props #(.HALF_CYC(HALF_CYC)) spms_props_inst (.i_ref_clk, .i_rst_n, .o_sclk,
    .o_sclk_oe, .o_mosi, .o_mosi_oe, .o_miso_oe, .o_ss_n, .o_ss_n_oe);

//--- tb/spms_partner.sv
/*
 Behavioural slave on the far side of the master link, either clock phase.
 Assumes the serial clock rests between frames.
*/
`timescale 1ns/10ps
module spms_partner (
    input  wire logic       i_sclk,
    input  wire logic       i_ss_n,
    input  wire logic       i_mosi,
    input  wire logic       i_cpol,
    input  wire logic       i_cpha,
    input  wire logic [7:0] i_reply,
    output logic            o_miso,
    output logic      [7:0] o_got
);
    logic [7:0] sh;
    logic       skip;
    initial o_miso = 1'b0;
    always @(negedge i_ss_n)
    begin
        sh = i_reply;
        o_miso = i_reply[7];
        skip = i_cpha;
    end
    always @(i_sclk)
        if (!i_ss_n)
        begin
            // Phase zero samples on leading edges, phase one on trailing; the first
            // launch of phase one only repeats the bit already shown at select fall
            if (i_sclk ^ i_cpol ^ i_cpha)
                o_got = {o_got[6:0], i_mosi};
            else if (skip)
                skip = 1'b0;
            else
            begin
                sh = sh << 1;
                o_miso = sh[7];
            end
        end
    // Released line shows the inverse so a stale bit cannot pass
    always @(posedge i_ss_n) o_miso = ~o_miso;
endmodule : spms_partner

//--- tb/tb_top.sv
/*
 Self-checking bench for spms_port: master frames against the partner, slave frame driven here.
 Assumes HALF_CYC=4 and the register port timing of the design.
*/
`timescale 1ns/10ps
module tb_top;
    logic       i_ref_clk, i_rst_n, i_wr, i_rd, tb_sclk, tb_mosi, tb_ss_n, cpol, cpha, p_miso;
    logic       o_sclk, o_sclk_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_ss_n, o_ss_n_oe;
    logic [7:0] i_addr, i_wr_data, o_rd_data, reply, got, v;
    int         mismatches, tests_run, falls, lows;
    wire logic  sclk_w = o_sclk_oe ? o_sclk : tb_sclk;
    wire logic  mosi_w = o_mosi_oe ? o_mosi : tb_mosi;
    wire logic  miso_w = o_miso_oe ? o_miso : p_miso;
    wire logic  ss_w = o_ss_n_oe ? o_ss_n : tb_ss_n;

    spms_port #(.HALF_CYC(4)) spms_port_inst (.i_ref_clk, .i_rst_n, .i_addr, .i_wr_data, .i_wr, .i_rd,
        .o_rd_data, .i_sclk(sclk_w), .o_sclk, .o_sclk_oe, .i_mosi(mosi_w), .o_mosi, .o_mosi_oe,
        .i_miso(miso_w), .o_miso, .o_miso_oe, .i_ss_n(ss_w), .o_ss_n, .o_ss_n_oe);
    spms_partner spms_partner_inst (.i_sclk(sclk_w), .i_ss_n(ss_w), .i_mosi(mosi_w), .i_cpol(cpol),
        .i_cpha(cpha), .i_reply(reply), .o_miso(p_miso), .o_got(got));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    always @(negedge ss_w) falls++;
    // Counts edges that see select low, so a frame length can be judged in cycles
    always @(posedge i_ref_clk) if (ss_w === 1'b0) lows++;

    task finish_test;
        if (mismatches == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    task chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rd_data;
    endtask : rd
    task idle_wait;
        repeat (8) @(posedge i_ref_clk);
        for (int n = 0; n < 2000 && ss_w !== 1'b1; n++) @(posedge i_ref_clk);
        chk({7'h00, ss_w}, 8'h01);
        repeat (4) @(posedge i_ref_clk);
    endtask : idle_wait

    task t_reset;
        logic [7:0] a [6];
        a = '{8'h9A, 8'h9B, 8'hE8, 8'hE9, 8'hEA, 8'h00};
        chk({7'h00, ss_w}, 8'h01);
        foreach (a[i])
        begin
            rd(a[i], v);
            chk(v, 8'h00);
        end
    endtask : t_reset
    task t_single;
        for (int p = 0; p < 3; p++)
        begin
            cpol = p[0];
            cpha = p[1];
            reply = 8'h3C;
            wr(spms_pkg::CFG2_OFS, {4'h0, p[0], p[1], 2'h0});
            wr(spms_pkg::CFG1_OFS, 8'hB0);
            repeat (4) @(posedge i_ref_clk);
            chk({7'h00, o_sclk}, {7'h00, cpol});
            wr(spms_pkg::TX_OFS, 8'hA5);
            idle_wait;
            chk(got, 8'hA5);
            rd(spms_pkg::STAT_OFS, v);
            chk(v, 8'h1A);
            rd(spms_pkg::RX_OFS, v);
            chk(v, 8'h3C);
            rd(spms_pkg::STAT_OFS, v);
            chk(v, 8'h02);
        end
    endtask : t_single
    task t_cont;
        int n, l;
        for (int i = 0; i < 3; i++)
        begin
            cpol = 1'b0;
            cpha = 1'b0;
            reply = 8'h5A;
            wr(spms_pkg::STAT_OFS, 8'h00);
            wr(spms_pkg::CFG2_OFS, {~i[1], 7'h00});
            wr(spms_pkg::CFG1_OFS, {5'h1E, i[0], 2'h0});
            n = falls;
            l = lows;
            wr(spms_pkg::TX_OFS, 8'h11);
            v = 8'h00;
            for (int k = 0; k < 200 && v[1] !== 1'b1; k++) rd(spms_pkg::STAT_OFS, v);
            chk({7'h00, v[1]}, 8'h01);
            wr(spms_pkg::TX_OFS, 8'h22);
            idle_wait;
            n = falls - n;
            l = lows - l;
            chk(n[7:0], 8'h01);
            // Lead and trail of one half period each, sixteen per byte, one more between bytes without streaming
            chk(l[7:0], i[1] ? 8'h8C : 8'h88);
            chk(got, 8'h22);
            rd(spms_pkg::STAT_OFS, v);
            chk(v, 8'h3A);
            rd(spms_pkg::RX_OFS, v);
            chk(v, i[0] ? 8'h00 : 8'h5A);
        end
    endtask : t_cont
    task t_slave;
        logic [7:0] s;
        wr(spms_pkg::CFG1_OFS, 8'hB8);
        #1 chk({7'h00, o_ss_n_oe}, 8'h00);
        wr(spms_pkg::CFG2_OFS, 8'h00);
        wr(spms_pkg::CFG1_OFS, 8'h80);
        wr(spms_pkg::TX_OFS, 8'hC3);
        tb_ss_n <= 1'b0;
        for (int b = 7; b >= 0; b--)
        begin
            repeat (4) @(posedge i_ref_clk);
            tb_sclk <= 1'b0;
            v = 8'h96 >> b;
            tb_mosi <= v[0];
            repeat (4) @(posedge i_ref_clk);
            tb_sclk <= 1'b1;
            s[b] = miso_w;
        end
        repeat (4) @(posedge i_ref_clk);
        tb_sclk <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        tb_ss_n <= 1'b1;
        tb_mosi <= ~tb_mosi;
        repeat (8) @(posedge i_ref_clk);
        chk(s, 8'hC3);
        rd(spms_pkg::RX_OFS, v);
        chk(v, 8'h96);
    endtask : t_slave

    initial
    begin
        #300000;
        mismatches++;
        finish_test;
    end
    initial
    begin
        {i_rst_n, i_wr, i_rd, tb_sclk, tb_mosi, cpol, cpha, i_addr, i_wr_data, reply} = '0;
        tb_ss_n = 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_reset;
        t_single;
        t_cont;
        t_slave;
        finish_test;
    end
endmodule : tb_top
